// ==== pwg_top.sv ====
// pwm generator: wishbone registers, duty/phase steering, dead time
`timescale 1ns/10ps
`include "pwg_defines.svh"
module pwg_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // pins
   output logic high_side_output,
   output logic low_side_output
);
   logic [15:0] pdc_reg;
   logic [15:0] sdc_reg;
   logic [15:0] phase_reg;
   logic [15:0] sphase_reg;
   logic [13:0] dt_reg;
   logic [13:0] altdt_reg;
   logic iue_reg;
   logic itb_reg;
   logic en_reg;
   pwg_pkg::pwg_dtc_type dtc_reg;
   pwg_pkg::pwg_mode_type mode_reg;
   logic [15:0] mper_reg;
   logic [15:0] pdc_act_reg;
   logic [15:0] sdc_act_reg;
   logic pp_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [1:0] out_reg;
   logic [13:0] dcnt_reg [2];
   logic [1:0] tgt;
   logic [13:0] dtv [2];
   logic [15:0] ctl_val;
   logic [15:0] io_val;
   logic [15:0] ctl_next;
   logic [15:0] io_next;
   logic [15:0] rd_data;
   logic wr;
   logic indep;

   pwg_chan_if hi_ch ();
   pwg_chan_if lo_ch ();

   // ************************************
   // helpers
   // ************************************
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] din,
         input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = din[7:0];
      end
      if (sel[1]) begin
         r[15:8] = din[15:8];
      end
      return r;
   endfunction : merge16

   // steps of 3 near either end of the period
   function automatic logic [15:0] coarse(input logic [15:0] d, input logic [15:0] p);
      logic [16:0] lim;
      lim = {1'b0, d} + 17'(`PWG_COARSE_CNT);
      if ((d < 16'(`PWG_COARSE_CNT)) || (lim > {1'b0, p})) begin
         return d - (d % `PWG_COARSE_STEP);
      end
      return d;
   endfunction : coarse

   // ************************************
   // bus slave
   // ************************************
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
   assign ctl_val = {en_reg, 5'h00, itb_reg, 1'b0, dtc_reg, 5'h00, iue_reg};
   assign io_val = {4'h0, mode_reg, 10'h000};
   assign ctl_next = merge16(ctl_val, wb_dat_i, wb_sel_i);
   assign io_next = merge16(io_val, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk) begin
      if (rst) begin
         pdc_reg <= `PWG_RST_ZERO;
         sdc_reg <= `PWG_RST_ZERO;
         phase_reg <= `PWG_RST_ZERO;
         sphase_reg <= `PWG_RST_ZERO;
         dt_reg <= 14'h0000;
         altdt_reg <= 14'h0000;
      end else if (wr) begin
         case (wb_adr_i)
            `PWG_OFF_PDC: pdc_reg <= merge16(pdc_reg, wb_dat_i, wb_sel_i);
            `PWG_OFF_SDC: sdc_reg <= merge16(sdc_reg, wb_dat_i, wb_sel_i);
            `PWG_OFF_PHASE: phase_reg <= merge16(phase_reg, wb_dat_i, wb_sel_i);
            `PWG_OFF_SPHASE: sphase_reg <= merge16(sphase_reg, wb_dat_i, wb_sel_i);
            `PWG_OFF_DT: dt_reg <= 14'(merge16({2'b00, dt_reg}, wb_dat_i, wb_sel_i));
            `PWG_OFF_ALTDT: begin
               altdt_reg <= 14'(merge16({2'b00, altdt_reg}, wb_dat_i, wb_sel_i));
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         iue_reg <= 1'b0;
         itb_reg <= 1'b0;
         en_reg <= 1'b0;
         dtc_reg <= pwg_pkg::PWG_DT_POS;
         mode_reg <= pwg_pkg::PWG_MODE_COMP;
         mper_reg <= `PWG_RST_MPER;
      end else if (wr) begin
         case (wb_adr_i)
            `PWG_OFF_CTL: begin
               iue_reg <= ctl_next[`PWG_CTL_IUE];
               itb_reg <= ctl_next[`PWG_CTL_ITB];
               en_reg <= ctl_next[`PWG_CTL_EN];
               dtc_reg <= pwg_pkg::pwg_dtc_type'(ctl_next[`PWG_CTL_DTC_HI:`PWG_CTL_DTC_LO]);
            end
            `PWG_OFF_IOCTL: begin
               mode_reg <= pwg_pkg::pwg_mode_type'(io_next[`PWG_IO_MODE_HI:`PWG_IO_MODE_LO]);
            end
            `PWG_OFF_MPER: mper_reg <= merge16(mper_reg, wb_dat_i, wb_sel_i);
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (wb_adr_i)
         `PWG_OFF_PDC: rd_data = pdc_reg;
         `PWG_OFF_SDC: rd_data = sdc_reg;
         `PWG_OFF_PHASE: rd_data = phase_reg;
         `PWG_OFF_SPHASE: rd_data = sphase_reg;
         `PWG_OFF_DT: rd_data = {2'b00, dt_reg};
         `PWG_OFF_ALTDT: rd_data = {2'b00, altdt_reg};
         `PWG_OFF_CTL: rd_data = ctl_val;
         `PWG_OFF_IOCTL: rd_data = io_val;
         `PWG_OFF_MPER: rd_data = mper_reg;
         `PWG_OFF_STAT: rd_data = {13'h0000, pp_reg, out_reg[1], out_reg[0]};
         `PWG_OFF_ACTDUTY: rd_data = pdc_act_reg;
         default: rd_data = 16'h0000;
      endcase
   end

   // unmapped addresses still ack, reading zero, so the master never hangs
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
         dat_reg <= {16'h0000, rd_data};
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // ************************************
   // steering of period, phase, duty
   // ************************************
   assign indep = (mode_reg == pwg_pkg::PWG_MODE_IND);
   assign hi_ch.enable = en_reg;
   assign lo_ch.enable = en_reg && indep;
   assign hi_ch.period = (itb_reg && !indep) ? phase_reg : mper_reg;
   assign lo_ch.period = itb_reg ? phase_reg : mper_reg;
   assign hi_ch.offset = (!itb_reg && !indep) ? phase_reg : 16'h0000;
   always_comb begin
      if (itb_reg) begin
         lo_ch.offset = indep ? sphase_reg : 16'h0000;
      end else begin
         lo_ch.offset = indep ? 16'(phase_reg + sphase_reg) : phase_reg;
      end
   end
   assign hi_ch.duty = coarse(pdc_act_reg, hi_ch.period);
   assign lo_ch.duty = coarse(indep ? sdc_act_reg : pdc_act_reg, lo_ch.period);

   // shadow to active transfer
   always_ff @(posedge clk) begin
      if (rst) begin
         pdc_act_reg <= 16'h0000;
         sdc_act_reg <= 16'h0000;
      end else begin
         if (iue_reg || hi_ch.start) begin
            pdc_act_reg <= pdc_reg;
         end
         if (iue_reg || lo_ch.start) begin
            sdc_act_reg <= sdc_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !en_reg) begin
         pp_reg <= 1'b0;
      end else if (hi_ch.start) begin
         pp_reg <= !pp_reg;
      end
   end

   pwg_chan u_hi (
      .clk(clk),
      .rst(rst),
      .ch(hi_ch.gen)
   );

   pwg_chan u_lo (
      .clk(clk),
      .rst(rst),
      .ch(lo_ch.gen)
   );

   // ************************************
   // output pair and dead time
   // ************************************
   always_comb begin
      case (mode_reg)
         pwg_pkg::PWG_MODE_COMP: tgt = {en_reg && !hi_ch.raw, hi_ch.raw};
         pwg_pkg::PWG_MODE_RED: tgt = {hi_ch.raw, hi_ch.raw};
         pwg_pkg::PWG_MODE_PP: tgt = {hi_ch.raw && pp_reg, hi_ch.raw && !pp_reg};
         pwg_pkg::PWG_MODE_IND: tgt = {lo_ch.raw, hi_ch.raw};
         default: tgt = 2'b00;
      endcase
   end
   assign dtv[0] = dt_reg;
   assign dtv[1] = altdt_reg;

   // positive delays rising edges, negative delays falling edges
   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg <= 2'b00;
         dcnt_reg[0] <= 14'h0000;
         dcnt_reg[1] <= 14'h0000;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (out_reg[i] == tgt[i]) begin
               dcnt_reg[i] <= 14'h0000;
            end else if ((((dtc_reg == pwg_pkg::PWG_DT_POS) && tgt[i])
                  || ((dtc_reg == pwg_pkg::PWG_DT_NEG) && !tgt[i]))
                  && (dcnt_reg[i] < dtv[i])) begin
               dcnt_reg[i] <= dcnt_reg[i] + 14'h0001;
            end else begin
               out_reg[i] <= tgt[i];
               dcnt_reg[i] <= 14'h0000;
            end
         end
      end
   end
   assign high_side_output = out_reg[0];
   assign low_side_output = out_reg[1];

   // ************************************
   // assertions
   // ************************************
   a_ack_single: assert property (@(posedge clk) disable iff (rst)
      ack_reg |=> !ack_reg) else $error("ack held two cycles");
   a_ack_follows_req: assert property (@(posedge clk) disable iff (rst)
      (wb_cyc_i && wb_stb_i && !ack_reg) |=> ack_reg) else $error("no ack after request");
   a_dt_top_zero: assert property (@(posedge clk) disable iff (rst)
      (wb_cyc_i && wb_stb_i && !ack_reg && wb_adr_i == `PWG_OFF_DT)
      |=> wb_dat_o[15:14] == 2'b00) else $error("dead time top bits not zero");
   a_altdt_top_zero: assert property (@(posedge clk) disable iff (rst)
      (wb_cyc_i && wb_stb_i && !ack_reg && wb_adr_i == `PWG_OFF_ALTDT)
      |=> wb_dat_o[31:14] == 18'h00000) else $error("alt dead time top bits not zero");
   a_reset_zero: assert property (@(posedge clk)
      $past(rst) |-> (pdc_reg == 16'h0000 && sphase_reg == 16'h0000 && dt_reg == 14'h0000))
      else $error("registers not zero after reset");
   a_sdc_unused: assert property (@(posedge clk) disable iff (rst)
      !indep |-> lo_ch.duty == hi_ch.duty) else $error("secondary duty used outside mode 11");
   a_itb_period: assert property (@(posedge clk) disable iff (rst)
      (itb_reg && !indep) |-> hi_ch.period == phase_reg) else $error("phase not used as period");
   a_duty_hold: assert property (@(posedge clk) disable iff (rst)
      (!iue_reg && !hi_ch.start) |=> pdc_act_reg == $past(pdc_act_reg))
      else $error("active duty changed off time base");
   a_no_deadtime: assert property (@(posedge clk) disable iff (rst)
      (dtc_reg == pwg_pkg::PWG_DT_OFF) |=> out_reg == $past(tgt)) else $error("edge delayed");
   a_comp_pair: assert property (@(posedge clk) disable iff (rst)
      (en_reg && mode_reg == pwg_pkg::PWG_MODE_COMP) |-> tgt[1] == !tgt[0])
      else $error("complementary pair not inverse");
   c_write_ack: cover property (@(posedge clk) wr ##1 ack_reg);
   c_indep_both: cover property (@(posedge clk) indep && out_reg == 2'b11);
   c_dead_band: cover property (@(posedge clk)
      dtc_reg == pwg_pkg::PWG_DT_POS && out_reg == 2'b00 && en_reg);
   a_iue_load: assert property (@(posedge clk) disable iff (rst)
      iue_reg |=> pdc_act_reg == $past(pdc_reg)) else $error("immediate duty not loaded");
   // first cycle of a delayed edge must keep the old level, else the pair may overlap
   a_pos_dead: assert property (@(posedge clk) disable iff (rst)
      (dtc_reg == pwg_pkg::PWG_DT_POS && dt_reg != 14'h0000 && !out_reg[0] && tgt[0]
      && dcnt_reg[0] == 14'h0000) |=> !out_reg[0]) else $error("rising edge not delayed");
   a_neg_dead: assert property (@(posedge clk) disable iff (rst)
      (dtc_reg == pwg_pkg::PWG_DT_NEG && dt_reg != 14'h0000 && out_reg[0] && !tgt[0]
      && dcnt_reg[0] == 14'h0000) |=> out_reg[0]) else $error("falling edge not delayed");
   c_push_pull: cover property (@(posedge clk)
      mode_reg == pwg_pkg::PWG_MODE_PP && out_reg[1]);
endmodule : pwg_top

// ==== pwg_defines.svh ====
// register map, field positions, reset values and timing counts of the pwm generator
// Notes on behaviour
// - independent mode: primary duty sets only the high-side pulse width.
// - complementary, redundant, push-pull: primary duty governs both outputs.
// - near 0% or 100% (within 40 ns) duty resolution coarsens to 3 LSB; the code coarsens only within one 25 ns clock count.
// - secondary duty acts only in independent mode, on the low side.
// - shared time base, modes 00/01/10: primary phase shifts both outputs.
// - shared time base, mode 11: primary phase shifts the low side only.
// - own time base, modes 00/01/10: primary phase is the period of both.
// - own time base, mode 11: primary phase is the low-side period only.
// - secondary phase offsets the low side, in independent mode only.
// - in modes 00/01/10 secondary phase affects neither output.
// - dead time holds 14 unsigned bits; bits 15-14 read zero.
// - alternate dead time holds 14 unsigned bits; top bits read zero.
// - duty, phase and dead-time registers reset to zero; duty and phase fully read/write.
// - time base select set: phase register gives period (mode 11: low side only); clear: master period.
// - pair mode: 00 complementary, 01 redundant, 10 push-pull, 11 independent.
// - without immediate update, duty values load at the time base start.
// - dead-time control: 00 positive, 01 negative, 10 none.
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH

// ************************************
// register offsets (byte addresses)
// ************************************
`define PWG_OFF_PDC 8'h00
`define PWG_OFF_SDC 8'h04
`define PWG_OFF_PHASE 8'h08
`define PWG_OFF_SPHASE 8'h0C
`define PWG_OFF_DT 8'h10
`define PWG_OFF_ALTDT 8'h14
`define PWG_OFF_CTL 8'h18
`define PWG_OFF_IOCTL 8'h1C
`define PWG_OFF_MPER 8'h20
`define PWG_OFF_STAT 8'h24
`define PWG_OFF_ACTDUTY 8'h28

// ************************************
// field positions
// ************************************
`define PWG_CTL_IUE 0
`define PWG_CTL_DTC_LO 6
`define PWG_CTL_DTC_HI 7
`define PWG_CTL_ITB 9
`define PWG_CTL_EN 15
`define PWG_IO_MODE_LO 10
`define PWG_IO_MODE_HI 11
`define PWG_DT_W 14

// ************************************
// reset values and timing
// ************************************
`define PWG_RST_ZERO 16'h0000
`define PWG_RST_MPER 16'hFFF8
`define PWG_CLK_NS 25
`define PWG_COARSE_NS 40
`define PWG_COARSE_CNT (((`PWG_COARSE_NS / `PWG_CLK_NS) < 1) ? 1 : (`PWG_COARSE_NS / `PWG_CLK_NS))
`define PWG_COARSE_STEP 16'h0003

`endif

// ==== pwg_pkg.sv ====
// types of the pwm generator
package pwg_pkg;
   typedef enum logic [1:0] {
      PWG_MODE_COMP = 2'b00,
      PWG_MODE_RED = 2'b01,
      PWG_MODE_PP = 2'b10,
      PWG_MODE_IND = 2'b11
   } pwg_mode_type;

   typedef enum logic [1:0] {
      PWG_DT_POS = 2'b00,
      PWG_DT_NEG = 2'b01,
      PWG_DT_OFF = 2'b10,
      PWG_DT_RSV = 2'b11
   } pwg_dtc_type;
endpackage : pwg_pkg

// ==== pwg_chan_if.sv ====
// signals between the register block and one time base channel
`timescale 1ns/10ps
interface pwg_chan_if;
   logic enable;
   logic [15:0] period;
   logic [15:0] offset;
   logic [15:0] duty;
   logic start;
   logic raw;
   logic [15:0] count;
   modport ctl (output enable, output period, output offset, output duty,
      input start, input raw, input count);
   modport gen (input enable, input period, input offset, input duty,
      output start, output raw, output count);
endinterface : pwg_chan_if

// ==== pwg_chan.sv ====
// one time base counter with phase offset and duty compare
`timescale 1ns/10ps
module pwg_chan (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // channel
   pwg_chan_if.gen ch
);
   logic [15:0] count_reg;

   // ************************************
   // time base
   // ************************************
   always_ff @(posedge clk) begin
      if (rst || !ch.enable) begin
         count_reg <= 16'h0000;
      end else if (count_reg >= ch.period) begin
         count_reg <= 16'h0000;
      end else begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // ************************************
   // compare
   // ************************************
   // window is not wrapped past the period: offset plus duty beyond it is cut short
   assign ch.raw = ch.enable && (count_reg >= ch.offset)
      && ({1'b0, count_reg} < ({1'b0, ch.offset} + {1'b0, ch.duty}));
   assign ch.start = ch.enable && (count_reg == 16'h0000);
   assign ch.count = count_reg;
endmodule : pwg_chan

// ==== pwg_sw_model.sv ====
// wishbone software model that loads and reads the generator registers
`timescale 1ns/10ps
module pwg_sw_model (
   // clock
   input wire logic clk,
   // wishbone master
   output logic wb_cyc,
   output logic wb_stb,
   output logic wb_we,
   output logic [7:0] wb_adr,
   output logic [3:0] wb_sel,
   output logic [31:0] wb_dat_w,
   input wire logic wb_ack,
   input wire logic [31:0] wb_dat_r
);
   initial begin
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat_w = 32'h00000000;
   end

   // ************************************
   // single classic cycle
   // ************************************
   // duty values handed in by callers are not range-checked; the bench also writes 0xFFFF and 0xABCD
   task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
      input logic [15:0] wd, output logic [15:0] rd);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_dat_w <= {16'h0000, wd};
      // no fixed latency assumed; the bench watchdog ends a hang
      do @(posedge clk); while (wb_ack !== 1'b1);
      rd = wb_dat_r[15:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk);
   endtask : access
endmodule : pwg_sw_model

// ==== pwg_top_tb.sv ====
// self-checking bench for the pwm generator registers and outputs
`timescale 1ns/10ps
`include "pwg_defines.svh"
module pwg_top_tb;
   typedef struct packed {
      logic [1:0] mode;
      logic independent_time_base_select;
      logic [1:0] dead_time_control;
      logic [1:0] sph;
      logic [15:0] hi;
      logic [15:0] lo;
   } pwg_row_type;
   logic clk;
   logic rst;
   logic cyc;
   logic stb;
   logic we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w;
   logic ack;
   logic [31:0] dat_r;
   logic hso;
   logic lso;
   logic [15:0] rd;
   int n_errors;
   int checked;
   int hi_cnt;
   int lo_cnt;
   logic [7:0] offs [6];
   pwg_row_type rows [9];

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   pwg_sw_model sw (.clk(clk), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr),
      .wb_sel(sel), .wb_dat_w(dat_w), .wb_ack(ack), .wb_dat_r(dat_r));
   pwg_top dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_ack_o(ack), .wb_dat_o(dat_r),
      .high_side_output(hso), .low_side_output(lso));

   // ************************************
   // tasks
   // ************************************
   task automatic stop_test;
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      sw.access(1'b1, a, 4'h3, d, rd);
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
      sw.access(1'b0, a, 4'hF, 16'h0000, rd);
      chk(what, exp, rd);
   endtask : rdchk

   // whole periods of both time bases fit 1050 cycles, so phase does not skew counts
   task automatic measure;
      hi_cnt = 0;
      lo_cnt = 0;
      repeat (1050) begin
         @(posedge clk);
         if (hso === 1'b1) hi_cnt++;
         if (lso === 1'b1) lo_cnt++;
      end
   endtask : measure

   // watchdog: the whole run needs about 10500 cycles
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      stop_test();
   end

   // ************************************
   // main sequence
   // ************************************
   initial begin
      rst = 1'b1;
      n_errors = 0;
      checked = 0;
      offs = '{`PWG_OFF_PDC, `PWG_OFF_SDC, `PWG_OFF_PHASE, `PWG_OFF_SPHASE, `PWG_OFF_DT,
         `PWG_OFF_ALTDT};
      // master period 24, duty 8 and 12, phase 20, dead time 2 and 3
      rows[0] = '{2'h0, 1'b0, 2'h2, 2'h3, 16'h00D2, 16'h0348};
      rows[1] = '{2'h1, 1'b0, 2'h2, 2'h0, 16'h00D2, 16'h00D2};
      rows[2] = '{2'h2, 1'b0, 2'h2, 2'h0, 16'h0069, 16'h0069};
      rows[3] = '{2'h3, 1'b0, 2'h2, 2'h0, 16'h0150, 16'h00D2};
      rows[4] = '{2'h3, 1'b0, 2'h2, 2'h3, 16'h0150, 16'h0054};
      rows[5] = '{2'h0, 1'b1, 2'h2, 2'h3, 16'h0190, 16'h028A};
      rows[6] = '{2'h3, 1'b1, 2'h2, 2'h3, 16'h0150, 16'h0258};
      rows[7] = '{2'h3, 1'b0, 2'h0, 2'h0, 16'h00FC, 16'h0054};
      rows[8] = '{2'h3, 1'b0, 2'h1, 2'h0, 16'h01A4, 16'h0150};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) rdchk("reset value", offs[i], 16'h0000);
      foreach (offs[i]) wr(offs[i], 16'hFFFF);
      foreach (offs[i]) rdchk("all ones", offs[i], (i < 4) ? 16'hFFFF : 16'h3FFF);
      sw.access(1'b1, `PWG_OFF_PDC, 4'h1, 16'hABCD, rd);
      rdchk("low byte write", `PWG_OFF_PDC, 16'hFFCD);
      wr(8'h3C, 16'h1234);
      rdchk("unmapped", 8'h3C, 16'h0000);
      wr(`PWG_OFF_MPER, 16'h0018);
      wr(`PWG_OFF_PDC, 16'h0008);
      wr(`PWG_OFF_SDC, 16'h000C);
      wr(`PWG_OFF_PHASE, 16'h0014);
      wr(`PWG_OFF_DT, 16'h0002);
      wr(`PWG_OFF_ALTDT, 16'h0003);
      for (int i = 0; i < 9; i++) begin
         wr(`PWG_OFF_CTL, 16'h0000);
         wr(`PWG_OFF_SPHASE, {14'h0000, rows[i].sph});
         wr(`PWG_OFF_IOCTL, {4'h0, rows[i].mode, 10'h000});
         wr(`PWG_OFF_CTL, {1'b1, 5'h00, rows[i].independent_time_base_select, 1'b0, rows[i].dead_time_control, 6'h00});
         repeat (80) @(posedge clk);
         measure();
         chk("high count", rows[i].hi, 16'(hi_cnt));
         chk("low count", rows[i].lo, 16'(lo_cnt));
      end
      wr(`PWG_OFF_CTL, 16'h0000);
      repeat (4) @(posedge clk);
      chk("disabled high", 16'h0000, {15'h0000, hso});
      chk("disabled low", 16'h0000, {15'h0000, lso});
      // disabled: no time base start, so only immediate update may move the active duty
      wr(`PWG_OFF_PDC, 16'h0010);
      rdchk("held duty", `PWG_OFF_ACTDUTY, 16'h0008);
      wr(`PWG_OFF_CTL, 16'h0001);
      rdchk("immediate duty", `PWG_OFF_ACTDUTY, 16'h0010);
      stop_test();
   end
endmodule : pwg_top_tb
